// file: bench/atp_aux_timer_pair_assertions.sv
`timescale 1ns/1ps
module atp_aux_timer_pair_assertions (
	// clock and reset
	input wire logic              clk,
	input wire logic              reset_n,
	// APB
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [7:0]        paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	// flags
	input wire logic [1:0]        auxIrqFlag,
	input wire logic [1:0]        auxIrqSet
);
	import atp_pkg::*;
	logic mapped;
	assign mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	sequence s_access;
		psel && penable;
	endsequence
	sequence s_rd_status;
		s_access ##0 (!pwrite && paddr == 8'h10);
	endsequence
	a_pready_high: assert property (pready)
		else $error("pready low");
	a_slverr_bad: assert property (s_access ##0 !mapped |-> pslverr)
		else $error("no error on unmapped access");
	a_slverr_good: assert property (s_access ##0 mapped |-> !pslverr)
		else $error("error on mapped access");
	a_rd_bad_zero: assert property (s_access ##0 (!pwrite && !mapped)
		|-> prdata == 32'h0) else $error("unmapped read not zero");
	a_rd_status: assert property (s_rd_status
		|-> prdata == {30'h0, $past(auxIrqFlag)}) else $error("status read");
	a_rd_ctrl_pad: assert property (s_access ##0 !pwrite
		##0 (paddr == 8'h00 || paddr == 8'h08)
		|-> prdata[31:16] == 16'h0 && prdata[12:10] == 3'h0)
		else $error("control pad bits");
	a_set_flag: assert property ((auxIrqSet & ~auxIrqFlag) == 2'h0)
		else $error("set pulse without flag");
	a_flag_cause: assert property (
		(auxIrqFlag & ~$past(auxIrqFlag) & ~auxIrqSet) == 2'h0)
		else $error("flag rose without event");
	a_flag_clear: assert property ($fell(auxIrqFlag[1]) |->
		$past(psel && penable && pwrite && paddr == 8'h10 && pwdata[1]))
		else $error("flag fell without clear");
	a_set_pulse: assert property (auxIrqSet[0] |=> !auxIrqSet[0])
		else $error("set pulse too long");
endmodule // atp_aux_timer_pair_assertions
bind atp_aux_timer_pair atp_aux_timer_pair_assertions chk (
	.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .auxIrqFlag(auxIrqFlag),
	.auxIrqSet(auxIrqSet)
);

// file: bench/atp_aux_timer_pair_tb.sv
`timescale 1ns/1ps
module atp_aux_timer_pair_tb;
	import atp_pkg::*;
	logic        clk, reset_n, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, r;
	logic        coreRun, coreToggleLatch, coreToggleHw, c, d;
	logic [15:0] coreCount, cap;
	atp_bps_t    blockPrescaler;
	logic [1:0]  countInPin, dirInPin, auxIrqFlag, auxIrqSet;
	int          failCount, numChecks, cyc, m, ev;
	int          mdl[2];
	always #4 clk = ~clk;
	atp_pin_model pm (.clk(clk), .coreRun(coreRun), .coreCount(coreCount),
		.coreToggleLatch(coreToggleLatch), .coreToggleHw(coreToggleHw),
		.blockPrescaler(blockPrescaler), .countInPin(countInPin),
		.dirInPin(dirInPin));
	atp_aux_timer_pair uut (.clk(clk), .reset_n(reset_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.coreRun(coreRun), .coreCount(coreCount),
		.coreToggleLatch(coreToggleLatch), .coreToggleHw(coreToggleHw),
		.blockPrescaler(blockPrescaler), .countInPin(countInPin),
		.dirInPin(dirInPin), .auxIrqFlag(auxIrqFlag), .auxIrqSet(auxIrqSet));
	task automatic summarize();
		if (failCount == 0 && numChecks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		numChecks++;
		if (seen !== exp) begin
			failCount++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] dt);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= dt;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rc(input logic [7:0] a, input int e);
		apb(1'b0, a, 32'h0);
		chk(r, e & 32'hFFFF);
	endtask
	// timer b counts only rising latch edges, so every second wrap
	task automatic wraps(input int n, input int da, input int db);
		for (int k = 0; k < n; k++) begin
			pm.wrap();
			mdl[0] += da;
			if (coreToggleLatch === 1'b1) begin
				mdl[1] += db;
			end
		end
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc > 10000) begin
			failCount++;
			summarize();
		end
	end
	initial begin
		clk = 1'b0;
		reset_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		void'($urandom(90700));
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		rc(8'h00, 0);
		rc(8'h14, 0);
		mdl[0] = $urandom & 16'h7FFF;
		apb(1'b1, 8'h04, mdl[0]);
		rc(8'h04, mdl[0]);
		// gate wants high, pin held low
		apb(1'b1, 8'h00, 32'h58);
		repeat (80) @(posedge clk);
		apb(1'b1, 8'h00, 32'h0);
		rc(8'h04, mdl[0]);
		// gate wants low and the pin is low: m basic ticks pass
		m = 1 + $urandom % 20;
		apb(1'b1, 8'h00, 32'h50);
		repeat (8 * m - 3) @(posedge clk);
		apb(1'b1, 8'h00, 32'h0);
		rc(8'h04, mdl[0] + m);
		// both timers under remote run; local bit set but ignored
		apb(1'b1, 8'h04, 32'h0);
		apb(1'b1, 8'h0C, 32'h0);
		apb(1'b1, 8'h00, 32'h240);
		apb(1'b1, 8'h08, 32'h240);
		repeat (40) @(posedge clk);
		rc(8'h04, 0);
		m = 1 + $urandom % 20;
		pm.setCore(1'b1, 16'h0);
		repeat (8 * m) @(posedge clk);
		pm.setCore(1'b0, 16'h0);
		rc(8'h04, m);
		rc(8'h0C, m);
		// capture on rising pin edge only, run bit clear
		cap = 16'($urandom);
		pm.setCore(1'b0, cap);
		apb(1'b1, 8'h08, 32'h29);
		pm.setPin(1, 1'b1, 1'b0);
		rc(8'h0C, cap);
		rc(8'h10, 2);
		apb(1'b1, 8'h10, 32'h3);
		pm.setCore(1'b0, cap ^ 16'h5A5A);
		pm.setPin(1, 1'b0, 1'b0);
		rc(8'h0C, cap);
		rc(8'h10, 0);
		// concatenation: a up on both edges, b down on rise
		apb(1'b1, 8'h04, 32'h0);
		apb(1'b1, 8'h0C, 32'h0);
		mdl = '{0, 0};
		apb(1'b1, 8'h00, 32'h4F);
		apb(1'b1, 8'h08, 32'hCD);
		wraps(1 + $urandom % 9, 1, -1);
		pm.swToggle();
		rc(8'h04, mdl[0]);
		rc(8'h0C, mdl[1]);
		apb(1'b1, 8'h00, 32'h14F);
		pm.setPin(0, 1'b0, 1'b1);
		wraps(1 + $urandom % 9, -1, -1);
		rc(8'h04, mdl[0]);
		rc(8'h0C, mdl[1]);
		// encoder on count-pin edges, flag on every counted edge
		apb(1'b1, 8'h10, 32'h3);
		apb(1'b1, 8'h00, 32'h79);
		c = 1'b0;
		d = 1'b1;
		ev = 0;
		for (int k = 0; k < 8; k++) begin
			if ($urandom % 2) begin
				c = ~c;
				mdl[0] += (c ^ d) ? 1 : -1;
				ev++;
			end else begin
				d = ~d;
			end
			pm.setPin(0, c, d);
			rc(8'h04, mdl[0]);
		end
		rc(8'h10, ev > 0);
		summarize();
	end
endmodule // atp_aux_timer_pair_tb

// file: bench/atp_pin_model.sv
`timescale 1ns/1ps
module atp_pin_model (
	// clock
	input  wire logic         clk,
	// core timer side
	output logic              coreRun,
	output logic [15:0]       coreCount,
	output logic              coreToggleLatch,
	output logic              coreToggleHw,
	output atp_pkg::atp_bps_t blockPrescaler,
	// pins
	output logic [1:0]        countInPin,
	output logic [1:0]        dirInPin
);
	import atp_pkg::*;
	initial begin
		coreRun = 1'b0;
		coreCount = 16'h0000;
		coreToggleLatch = 1'b0;
		coreToggleHw = 1'b0;
		blockPrescaler = 2'h0;
		countInPin = 2'h0;
		dirInPin = 2'h0;
	end
	task automatic setCore(input logic run, input logic [15:0] cnt);
		coreRun <= run;
		coreCount <= cnt;
	endtask
	// wrap toggles the latch and qualifies it with the hardware pulse
	task automatic wrap();
		@(posedge clk);
		coreToggleLatch <= ~coreToggleLatch;
		coreToggleHw <= 1'b1;
		@(posedge clk);
		coreToggleHw <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	// software write to the latch: no qualifying pulse
	task automatic swToggle();
		@(posedge clk);
		coreToggleLatch <= ~coreToggleLatch;
		repeat (3) @(posedge clk);
	endtask
	// hold covers sync delay plus the slowest sampling tick used
	task automatic setPin(input int i, input logic c, input logic d);
		countInPin[i] <= c;
		dirInPin[i] <= d;
		repeat (40) @(posedge clk);
	endtask
endmodule // atp_pin_model

// file: rtl/atp_aux_timer_pair.sv
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "atp_defs.svh"
// Function
// - Mode 000: count the prescaled module clock.
// - Modes 010/011 are gated timer; mode bit 0 picks the gate level.
// - Code 010 counts while gate low, 011 while gate high.
// - Gate level changes never raise an interrupt request.
// - Remote select 0 uses local run bit, 1 uses core run bit.
// - Selected run bit starts and stops the timer in modes 000, 001, 01x and 11x; capture ignores it.
// - Gated timer advances only when running and gate active.
// - Core run bit starts remote timers in the same clock cycle.
// - Count register reads current count; writes load a new count.
// - Direction chosen by software bit or by external direction pin.
// - Mode 001 counts selected edges of count pin or core toggle latch.
// - Only hardware overflow toggles of the latch count; writes never do.
// - Both latch edges: count every core wrap, forming 32 bits.
// - One latch edge: count every second core wrap, forming 33 bits.
// - Concatenated timers keep independent count directions.
// - Mode 101 copies core count into the timer on chosen pin edge.
// - Capture edge uses two low select bits; bit 2 is ignored.
// - Capture mode never counts, whatever the run bit.
// - Each capture sets the timer's interrupt flag with the load.
// - Modes 110/111 count encoder transitions on one or both pins.
// - Encoder direction and interrupts behave as in the core timer.
// - Encoder direction follows edge type and level of the other input.
// - Code 110 interrupts on direction change, 111 on every edge.
// - No output toggle latch and no output pin in any mode.
module atp_aux_timer_pair (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              reset_n,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// core timer side, same clock
	input  wire logic              coreRun,
	input  wire logic [15:0]       coreCount,
	input  wire logic              coreToggleLatch,
	input  wire logic              coreToggleHw,
	input  wire atp_pkg::atp_bps_t blockPrescaler,
	// pins, index 0 is timer a, 1 is timer b
	input  wire logic [1:0]        countInPin,
	input  wire logic [1:0]        dirInPin,
	// flags
	output logic      [1:0]        auxIrqFlag,
	output logic      [1:0]        auxIrqSet
);
	import atp_pkg::*;

	wire                     basicTick;
	wire [`ATP_DIV_TAPS-1:0] divTick;
	wire [3:0]               pinSync;
	wire [1:0]               countInSync;
	wire [1:0]               dirInSync;

	atp_prescaler uPrescaler (
		.clk            (clk),
		.reset_n        (reset_n),
		.blockPrescaler (blockPrescaler),
		.basicTick      (basicTick),
		.divTick        (divTick)
	);

	atp_sync #(
		.WIDTH (4)
	) uSync (
		.clk     (clk),
		.reset_n (reset_n),
		.asyncIn ({dirInPin, countInPin}),
		.syncOut (pinSync)
	);

	assign countInSync = pinSync[1:0];
	assign dirInSync   = pinSync[3:2];

	// bus decode
	wire        setupPhase;
	wire        accessWrite;
	wire        hitACtrl;
	wire        hitACount;
	wire        hitBCtrl;
	wire        hitBCount;
	wire        hitStatus;
	wire        addrHit;
	wire [1:0]  wrCtrl;
	wire [1:0]  wrCount;
	wire        wrStatus;
	wire [31:0] readData;
	wire [31:0] rdACtrl;
	wire [31:0] rdACount;
	wire [31:0] rdBCtrl;
	wire [31:0] rdBCount;
	wire [31:0] rdStatus;
	logic       errReg;
	logic [31:0] prdataReg;

	wire [15:0] ctrlView [0:1];
	wire [15:0] countView [0:1];
	wire [1:0]  irqView;
	wire [1:0]  irqSetView;

	assign setupPhase  = psel & ~penable;
	assign accessWrite = psel & penable & pwrite;
	assign hitACtrl    = (paddr == `ATP_OFF_A_CTRL);
	assign hitACount   = (paddr == `ATP_OFF_A_COUNT);
	assign hitBCtrl    = (paddr == `ATP_OFF_B_CTRL);
	assign hitBCount   = (paddr == `ATP_OFF_B_COUNT);
	assign hitStatus   = (paddr == `ATP_OFF_STATUS);
	assign addrHit     = hitACtrl | hitACount | hitBCtrl | hitBCount |
	                     hitStatus;

	// writes land only at the access edge; unmapped writes are dropped
	assign wrCtrl   = {accessWrite & hitBCtrl, accessWrite & hitACtrl};
	assign wrCount  = {accessWrite & hitBCount, accessWrite & hitACount};
	assign wrStatus = accessWrite & hitStatus;

	assign rdACtrl  = {16'h0000, ctrlView[0]};
	assign rdACount = {16'h0000, countView[0]};
	assign rdBCtrl  = {16'h0000, ctrlView[1]};
	assign rdBCount = {16'h0000, countView[1]};
	assign rdStatus = {30'h0, irqView};

	assign readData = hitACtrl  ? rdACtrl :
	                  hitACount ? rdACount :
	                  hitBCtrl  ? rdBCtrl :
	                  hitBCount ? rdBCount :
	                  hitStatus ? rdStatus :
	                              32'h00000000;

	// read data sampled in setup so it comes from a flop in access
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			prdataReg <= 32'h00000000;
		end else if (setupPhase) begin
			prdataReg <= readData;
		end
	end

	// error decided with the address, shown only in access
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			errReg <= 1'b0;
		end else if (setupPhase) begin
			errReg <= ~addrHit;
		end
	end

	assign prdata  = prdataReg;
	assign pready  = 1'b1;
	assign pslverr = psel & penable & errReg;

	// toggle latch edges from hardware wraps only
	wire otlRise;
	wire otlFall;

	assign otlRise = coreToggleHw & coreToggleLatch;
	assign otlFall = coreToggleHw & ~coreToggleLatch;

	for (genvar t = 0; t < 2; t++) begin : gTimer
		logic [15:0] ctrlReg;
		logic [15:0] ctrlNext;
		logic [15:0] countReg;
		logic [15:0] countNext;
		logic        irqReg;
		logic        irqNext;
		logic        irqSetReg;
		logic        inLevelReg;
		logic        dirLevelReg;
		logic        stepEn;
		logic        stepDown;
		atp_mode_t   mode;

		wire [2:0]  inSel;
		wire        runSel;
		wire        gateOpen;
		wire        timeTick;
		wire        inRise;
		wire        inFall;
		wire        dirRise;
		wire        dirFall;
		wire        pinEvt;
		wire        otlEvt;
		wire        counterEvt;
		wire        encInEvt;
		wire        encDirEvt;
		wire        encEvt;
		wire        encDown;
		wire        swDown;
		wire        isEnc;
		wire        isCapture;
		wire        capLoad;
		wire [1:0]  capSel;
		wire        capEvt;
		wire        wrapEvt;
		wire        dirChange;
		wire        encIrq;
		wire        irqSet;
		wire [15:0] countStep;
		wire [15:0] ctrlWritten;

		assign inSel = ctrlReg[`ATP_I_LSB +: `ATP_I_W];
		assign mode  = atp_mode_t'(ctrlReg[`ATP_M_LSB +: `ATP_M_W]);

		// remote run comes straight from the core flop, no extra stage
		assign runSel = ctrlReg[`ATP_RC_BIT] ? coreRun :
		                                       ctrlReg[`ATP_R_BIT];

		// pins are judged once per basic tick, so a level held for the
		// prescaler factor is always seen
		assign inRise  = basicTick & countInSync[t] & ~inLevelReg;
		assign inFall  = basicTick & ~countInSync[t] & inLevelReg;
		assign dirRise = basicTick & dirInSync[t] & ~dirLevelReg;
		assign dirFall = basicTick & ~dirInSync[t] & dirLevelReg;

		assign gateOpen = (inLevelReg == ctrlReg[`ATP_M_LSB]);
		assign timeTick = divTick[inSel];

		// select code bit 0 rising, bit 1 falling, both for any edge
		assign pinEvt = (inSel[0] & inRise) | (inSel[1] & inFall);
		assign otlEvt = (inSel[0] & otlRise) |
		                (inSel[1] & otlFall);
		assign counterEvt = inSel[2] ? otlEvt : pinEvt;

		assign encInEvt  = inSel[0] & (inRise | inFall);
		assign encDirEvt = inSel[1] & (dirRise | dirFall);
		assign encEvt    = encInEvt | encDirEvt;
		// count pin edge wins if both pins move in one tick
		assign encDown = encInEvt ? (inRise ? dirLevelReg : ~dirLevelReg) :
		                 (dirRise ? ~inLevelReg : inLevelReg);

		// each timer's own bits; nothing ties a to the core direction
		assign swDown = ctrlReg[`ATP_UD_BIT] ^
		                (ctrlReg[`ATP_UDE_BIT] & dirLevelReg);

		always_comb begin
			stepEn   = 1'b0;
			stepDown = swDown;
			unique case (mode)
				ATP_TIMER: begin
					stepEn = runSel & timeTick;
				end
				ATP_COUNTER: begin
					stepEn = runSel & counterEvt;
				end
				ATP_GATED_LO, ATP_GATED_HI: begin
					stepEn = runSel & timeTick & gateOpen;
				end
				ATP_RELOAD, ATP_CAPTURE: begin
					stepEn = 1'b0;
				end
				ATP_ENC_ROT, ATP_ENC_EDGE: begin
					stepEn   = runSel & encEvt;
					stepDown = encDown;
				end
			endcase
		end

		assign isEnc     = (mode == ATP_ENC_ROT) | (mode == ATP_ENC_EDGE);
		assign isCapture = (mode == ATP_CAPTURE);
		// capture looks at the two low select bits only
		assign capSel    = inSel[1:0];
		assign capEvt    = (capSel[0] & inRise) | (capSel[1] & inFall);
		assign capLoad   = isCapture & capEvt;
		assign countStep = stepDown ? countReg - 16'h0001 :
		                              countReg + 16'h0001;
		assign wrapEvt   = stepEn & ~isEnc &
		                   (stepDown ? (countReg == 16'h0000) :
		                               (countReg == 16'hFFFF));
		assign dirChange = stepEn & isEnc &
		                   (stepDown != ctrlReg[`ATP_RDIR_BIT]);
		assign encIrq    = isEnc & stepEn &
		                   ((mode == ATP_ENC_EDGE) | dirChange);
		// gate level is no source here, only wraps, captures, encoder
		assign irqSet    = capLoad | wrapEvt | encIrq;

		// software load beats a simultaneous count or capture
		assign countNext = wrCount[t] ? pwdata[15:0] :
		                   capLoad    ? coreCount :
		                   stepEn     ? countStep :
		                                countReg;

		assign ctrlWritten = wrCtrl[t] ?
		                     ((pwdata[15:0] & `ATP_CTRL_WMASK) |
		                      (ctrlReg & ~`ATP_CTRL_WMASK)) : ctrlReg;

		// hardware sets of the sticky status bits win over a clearing write
		always_comb begin
			ctrlNext = ctrlWritten;
			if (isEnc & stepEn) begin
				ctrlNext[`ATP_EDGE_BIT] = 1'b1;
				ctrlNext[`ATP_RDIR_BIT] = stepDown;
			end
			if (dirChange) begin
				ctrlNext[`ATP_CHDIR_BIT] = 1'b1;
			end
		end

		assign irqNext = irqSet | (irqReg & ~(wrStatus & pwdata[t]));

		always_ff @(posedge clk or negedge reset_n) begin
			if (!reset_n) begin
				ctrlReg  <= `ATP_CTRL_RESET;
				countReg <= `ATP_COUNT_RESET;
			end else begin
				ctrlReg  <= ctrlNext;
				countReg <= countNext;
			end
		end

		always_ff @(posedge clk or negedge reset_n) begin
			if (!reset_n) begin
				irqReg    <= 1'b0;
				irqSetReg <= 1'b0;
			end else begin
				irqReg    <= irqNext;
				irqSetReg <= irqSet;
			end
		end

		// held levels move only on a basic tick, the edge reference
		always_ff @(posedge clk or negedge reset_n) begin
			if (!reset_n) begin
				inLevelReg  <= 1'b0;
				dirLevelReg <= 1'b0;
			end else if (basicTick) begin
				inLevelReg  <= countInSync[t];
				dirLevelReg <= dirInSync[t];
			end
		end

		assign ctrlView[t]   = ctrlReg;
		assign countView[t]  = countReg;
		assign irqView[t]    = irqReg;
		assign irqSetView[t] = irqSetReg;
	end

	// only flags leave the block; no toggle latch, no pin driven
	assign auxIrqFlag = irqView;
	assign auxIrqSet  = irqSetView;

endmodule // atp_aux_timer_pair

// file: rtl/atp_defs.svh
`ifndef ATP_DEFS_SVH
`define ATP_DEFS_SVH

// register byte offsets on the APB
`define ATP_OFF_A_CTRL  8'h00
`define ATP_OFF_A_COUNT 8'h04
`define ATP_OFF_B_CTRL  8'h08
`define ATP_OFF_B_COUNT 8'h0C
`define ATP_OFF_STATUS  8'h10

// control register field positions
`define ATP_I_LSB     0
`define ATP_I_W       3
`define ATP_M_LSB     3
`define ATP_M_W       3
`define ATP_R_BIT     6
`define ATP_UD_BIT    7
`define ATP_UDE_BIT   8
`define ATP_RC_BIT    9
`define ATP_EDGE_BIT  13
`define ATP_CHDIR_BIT 14
`define ATP_RDIR_BIT  15

// reset values and software-writable control bits
`define ATP_CTRL_RESET  16'h0000
`define ATP_COUNT_RESET 16'h0000
`define ATP_CTRL_WMASK  16'h63FF

// block prescaler: last count of the divider for each field code
`define ATP_BPS_TOP_00 5'h07
`define ATP_BPS_TOP_01 5'h03
`define ATP_BPS_TOP_10 5'h1F
`define ATP_BPS_TOP_11 5'h0F

// number of individual prescaler taps (2^0 .. 2^7)
`define ATP_DIV_TAPS 8

`endif

// file: rtl/atp_pkg.sv
package atp_pkg;

	typedef logic [1:0] atp_bps_t;

	typedef enum logic [2:0] {
		ATP_TIMER    = 3'h0,
		ATP_COUNTER  = 3'h1,
		ATP_GATED_LO = 3'h2,
		ATP_GATED_HI = 3'h3,
		ATP_RELOAD   = 3'h4,
		ATP_CAPTURE  = 3'h5,
		ATP_ENC_ROT  = 3'h6,
		ATP_ENC_EDGE = 3'h7
	} atp_mode_t;

endpackage

// file: rtl/atp_prescaler.sv
`timescale 1ns/1ps
`include "atp_defs.svh"
module atp_prescaler (
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     reset_n,
	// block prescaler code from the core timer control
	input  wire atp_pkg::atp_bps_t        blockPrescaler,
	// enables
	output logic                          basicTick,
	output logic [`ATP_DIV_TAPS-1:0]      divTick
);
	import atp_pkg::*;

	logic [4:0] baseCntReg;
	logic [6:0] divCntReg;
	wire  [4:0] baseTop;

	assign baseTop = (blockPrescaler == 2'h0) ? `ATP_BPS_TOP_00 :
	                 (blockPrescaler == 2'h1) ? `ATP_BPS_TOP_01 :
	                 (blockPrescaler == 2'h2) ? `ATP_BPS_TOP_10 :
	                                            `ATP_BPS_TOP_11;
	// >= so a smaller code picked mid-count does not wrap the long way
	assign basicTick = (baseCntReg >= baseTop);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			baseCntReg <= 5'h00;
			divCntReg  <= 7'h00;
		end else if (basicTick) begin
			baseCntReg <= 5'h00;
			divCntReg  <= divCntReg + 7'h01;
		end else begin
			baseCntReg <= baseCntReg + 5'h01;
		end
	end

	assign divTick[0] = basicTick;
	for (genvar k = 1; k < `ATP_DIV_TAPS; k++) begin : gTap
		assign divTick[k] = basicTick & (&divCntReg[k-1:0]);
	end

endmodule // atp_prescaler

// file: rtl/atp_sync.sv
`timescale 1ns/1ps
module atp_sync #(
	parameter int WIDTH = 4
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             reset_n,
	// asynchronous levels in, synchronised levels out
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);
	import atp_pkg::*;

	logic [WIDTH-1:0] stage1Reg;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			stage1Reg <= '0;
			syncOut   <= '0;
		end else begin
			stage1Reg <= asyncIn;
			syncOut   <= stage1Reg;
		end
	end

endmodule // atp_sync
